// ===== logic/lghp_pkg.sv
/*
 shared constants and state codes of the generic host port, device and host ends.
 assumes a 25 MHz clk on both ends and straps that are static while reset is released.
*/
// Operation
// - sixteen-bit data bus, two generic modes
// - strap low selects per-byte strobe mode
// - strap high selects shared strobe mode
// - per-byte mode: byte write strobes, active low
// - per-byte mode: byte read strobes, active low
// - shared mode: high byte enable qualifies both
// - shared mode: single active-low write enable
// - shared mode: single active-low read enable
// - shared mode: direction pin tied high, unused
// - wait held until data ready or accepted
// - wait held while refresh contends, until grant
// - host stretches cycle while wait asserted
// - host decodes chip select from high address; lghp_host drives it low on every request
// - endian strap latched at reset orders bytes
// - host wires bus to correct data lines
// - port timed by its own bus clock
// - asynchronous strobes synchronised inside device
// - seventeen address inputs, 128K byte space
// - low addresses reach display memory
// - top 32 bytes reach control registers
// - space repeats every 128K unless decoded
package lghp_pkg;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 16;
	localparam logic [16:0] MEM_LIMIT = 17'h1_3FFF;
	localparam logic [16:0] REG_BASE = 17'h1_FFE0;
	localparam int MEM_WORDS = 40960;
	localparam int REG_WORDS = 16;
	localparam int CLK_PERIOD_NS = 40;
	localparam int BUS_CLOCK_PERIOD_NS = 320;
	localparam logic [2:0] BUS_CLOCK_HALF = 3'(BUS_CLOCK_PERIOD_NS / (2 * CLK_PERIOD_NS));
	localparam logic [2:0] STRAP_TAKE_AGE = 3'h3;
	localparam logic [4:0] CTL_IDLE = 5'h1F;

	typedef enum logic [1:0] {
		D_IDLE = 2'b00,
		D_ARB = 2'b01,
		D_EDGE = 2'b10,
		D_DONE = 2'b11
	} lghp_dstate_t;

	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_SETUP = 3'b001,
		H_STROBE = 3'b010,
		H_WAIT_HI = 3'b011,
		H_HOLD = 3'b100
	} lghp_hstate_t;
endpackage

// ===== logic/lghp_if.sv
/*
 pin bundle between host glue and device port.
 assumes at most one side enables its data drivers at any time.
*/
`timescale 1ns/100ps
`default_nettype none
interface lghp_if;
	logic chip_select_n;
	logic low_byte_write_strobe_n;
	logic high_byte_write_strobe_n;
	logic read_strobe_n;
	logic high_byte_read_strobe_n;
	logic [16:0] host_addr_in;
	logic [15:0] host_data_io;
	logic [15:0] dev_data_out;
	logic dev_data_oe;
	logic [15:0] host_data_out;
	logic host_data_oe;
	logic wait_n;
	logic host_port_clock_in;
	logic bus_status_strap;
	logic endian_strap;

	// resolved level of the shared data lines
	assign host_data_io = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 16'h0000);

	modport dev (
		input chip_select_n, low_byte_write_strobe_n, high_byte_write_strobe_n,
		input read_strobe_n, high_byte_read_strobe_n, host_addr_in, host_data_io,
		input host_port_clock_in, bus_status_strap, endian_strap,
		output dev_data_out, dev_data_oe, wait_n
	);
	modport host (
		output chip_select_n, low_byte_write_strobe_n, high_byte_write_strobe_n,
		output read_strobe_n, high_byte_read_strobe_n, host_addr_in,
		output host_data_out, host_data_oe, host_port_clock_in, bus_status_strap, endian_strap,
		input host_data_io, wait_n
	);
endinterface
`default_nettype wire

// ===== logic/lghp_dev.sv
/*
 device end of the generic host port: synchroniser, arbiter, memory and registers.
 assumes host strobes asynchronous to clk, refresh_busy from clk domain logic.
*/
`timescale 1ns/100ps
`default_nettype none
module lghp_dev (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// pins
	lghp_if.dev bus,
	// core side
	input wire logic refresh_busy,
	output logic host_granted,
	output logic mode_shared,
	output logic endian_big
);
	typedef struct packed {
		logic [4:0] ctl_s1;
		logic [4:0] ctl_s2;
		logic [16:0] addr_s1;
		logic [16:0] addr_s2;
		logic [15:0] data_s1;
		logic [15:0] data_s2;
		logic [2:0] misc_s1;
		logic [2:0] misc_s2;
		logic bclk_prev;
		logic [2:0] strap_age;
		logic mode_shared;
		logic endian_big;
		lghp_pkg::lghp_dstate_t state;
		logic wait_n;
		logic [15:0] dout;
		logic doe;
		logic host_granted;
		logic op_write;
		logic [1:0] op_be;
		logic [16:0] op_addr;
		logic [15:0] op_wdata;
	} lghp_dev_reg_t;

	lghp_dev_reg_t r;
	lghp_dev_reg_t next_r;
	logic [15:0] mem_rd;
	logic [15:0] reg_rd;
	logic [15:0] wdata_sw;
	logic [1:0] mem_we;
	logic [1:0] reg_we;
	logic [15:0] rdata;
	logic cs_act, wr_any, rd_any;
	logic [1:0] lane_en, store_be;

	// region decode, shared by read and write paths
	function automatic logic lghp_is_mem(input logic [16:0] a);
		return a <= lghp_pkg::MEM_LIMIT;
	endfunction
	function automatic logic lghp_is_reg(input logic [16:0] a);
		return a >= lghp_pkg::REG_BASE;
	endfunction
	function automatic logic [15:0] lghp_swap(input logic [15:0] d, input logic en);
		return en ? {d[7:0], d[15:8]} : d;
	endfunction

	// word read from the addressed region, zero in the gap
	always_comb begin
		if (lghp_is_mem(r.op_addr)) begin
			rdata = mem_rd;
		end else if (lghp_is_reg(r.op_addr)) begin
			rdata = reg_rd;
		end else begin
			rdata = 16'h0000;
		end
	end

	// next state
	always_comb begin
		next_r = r;
		next_r.host_granted = 1'b0;
		mem_we = 2'b00;
		reg_we = 2'b00;
		// two-stage synchronisers for every pin input
		next_r.ctl_s1 = {bus.chip_select_n, bus.low_byte_write_strobe_n,
			bus.high_byte_write_strobe_n, bus.read_strobe_n, bus.high_byte_read_strobe_n};
		next_r.ctl_s2 = r.ctl_s1;
		next_r.addr_s1 = bus.host_addr_in;
		next_r.addr_s2 = r.addr_s1;
		next_r.data_s1 = bus.host_data_io;
		next_r.data_s2 = r.data_s1;
		next_r.misc_s1 = {bus.host_port_clock_in, bus.bus_status_strap, bus.endian_strap};
		next_r.misc_s2 = r.misc_s1;
		next_r.bclk_prev = r.misc_s2[2];
		// straps are caught once after release, then held; the far end's strap flops
		// and our two sync stages take three edges, so the catch is on the fourth
		if (r.strap_age != lghp_pkg::STRAP_TAKE_AGE + 3'h1) begin
			next_r.strap_age = r.strap_age + 3'h1;
			if (r.strap_age == lghp_pkg::STRAP_TAKE_AGE) begin
				next_r.mode_shared = r.misc_s2[1];
				next_r.endian_big = r.misc_s2[0];
			end
		end

		// strobe decode per mode
		cs_act = ~r.ctl_s2[4];
		if (r.mode_shared) begin
			wr_any = ~r.ctl_s2[3];
			rd_any = ~r.ctl_s2[1];
			lane_en = {~r.ctl_s2[2], ~r.addr_s2[0]};
		end else begin
			wr_any = ~r.ctl_s2[3] | ~r.ctl_s2[2];
			rd_any = ~r.ctl_s2[1] | ~r.ctl_s2[0];
			lane_en = wr_any ? {~r.ctl_s2[2], ~r.ctl_s2[3]} : {~r.ctl_s2[0], ~r.ctl_s2[1]};
		end
		store_be = r.endian_big ? {r.op_be[0], r.op_be[1]} : r.op_be;

		// access sequence: take, arbitrate, pace on bus clock, wait for strobes to drop
		unique case (r.state)
			lghp_pkg::D_IDLE: begin
				// take a request only once straps are latched and strobes are synchronised
				next_r.doe = 1'b0;
				if (r.strap_age == lghp_pkg::STRAP_TAKE_AGE + 3'h1 && cs_act
					&& (wr_any || rd_any)) begin
					next_r.wait_n = 1'b0;
					next_r.op_write = wr_any;
					next_r.op_be = lane_en;
					next_r.op_addr = {r.addr_s2[16:1], 1'b0};
					next_r.op_wdata = r.data_s2;
					next_r.state = lghp_pkg::D_ARB;
				end
			end
			lghp_pkg::D_ARB: begin
				// hold the host off while refresh owns the memory
				if (!refresh_busy) begin
					next_r.host_granted = 1'b1;
					if (r.op_write) begin
						mem_we = lghp_is_mem(r.op_addr) ? store_be : 2'b00;
						reg_we = lghp_is_reg(r.op_addr) ? store_be : 2'b00;
					end else begin
						next_r.dout = lghp_swap(rdata, r.endian_big)
							& {{8{r.op_be[1]}}, {8{r.op_be[0]}}};
					end
					next_r.state = lghp_pkg::D_EDGE;
				end
			end
			lghp_pkg::D_EDGE: begin
				// completion is paced by a rising bus clock edge
				if (r.misc_s2[2] && !r.bclk_prev) begin
					next_r.wait_n = 1'b1;
					next_r.doe = ~r.op_write;
					next_r.state = lghp_pkg::D_DONE;
				end
			end
			lghp_pkg::D_DONE: begin
				// read data stands until the host lets go of its strobes
				if (!cs_act || !(wr_any || rd_any)) begin
					next_r.doe = 1'b0;
					next_r.state = lghp_pkg::D_IDLE;
				end
			end
		endcase
	end

	// state register, strobes seen idle during reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
			r.ctl_s1 <= lghp_pkg::CTL_IDLE;
			r.ctl_s2 <= lghp_pkg::CTL_IDLE;
			r.wait_n <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// write data in storage byte order, shared by both lanes
	assign wdata_sw = lghp_swap(r.op_wdata, r.endian_big);

	// byte lane storage: each lane owns its arrays, so every array has one writer
	genvar b;
	for (b = 0; b < 2; b++) begin : g_lane
		logic [7:0] mem_lane [0:lghp_pkg::MEM_WORDS-1];
		logic [7:0] reg_lane [0:lghp_pkg::REG_WORDS-1];
		// writes land on the grant edge
		always_ff @(posedge clk) begin
			if (mem_we[b]) begin
				mem_lane[r.op_addr[16:1]] <= wdata_sw[8*b +: 8];
			end
			if (reg_we[b]) begin
				reg_lane[r.op_addr[4:1]] <= wdata_sw[8*b +: 8];
			end
		end
		// lane read ports, chosen by region above
		assign mem_rd[8*b +: 8] = mem_lane[r.op_addr[16:1]];
		assign reg_rd[8*b +: 8] = reg_lane[r.op_addr[4:1]];
	end

	// pins and core outputs straight from flops
	assign bus.wait_n = r.wait_n;
	assign bus.dev_data_out = r.dout;
	assign bus.dev_data_oe = r.doe;
	assign host_granted = r.host_granted;
	assign mode_shared = r.mode_shared;
	assign endian_big = r.endian_big;
endmodule
`default_nettype wire

// ===== logic/lghp_host.sv
/*
 host end: glue that turns word requests into generic-mode strobe cycles.
 assumes the device answers with wait low then high on every cycle it sees.
*/
`timescale 1ns/100ps
`default_nettype none
module lghp_host (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// pins
	lghp_if.host bus,
	// configuration
	input wire logic mode_shared_sel,
	input wire logic big_endian_sel,
	// request
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [16:0] req_addr,
	input wire logic [15:0] req_wdata,
	input wire logic [1:0] req_byte_en,
	output logic req_ready,
	// answer
	output logic resp_valid,
	output logic [15:0] resp_rdata
);
	typedef struct packed {
		logic wait_s1;
		logic wait_s2;
		logic [15:0] data_s1;
		logic [15:0] data_s2;
		logic [2:0] div_cnt;
		logic bclk;
		logic bs;
		logic endian;
		lghp_pkg::lghp_hstate_t state;
		logic cs_n;
		logic we0_n, we1_n, rd0_n, rd1_n;
		logic [16:0] addr;
		logic [15:0] dout;
		logic doe;
		logic op_write;
		logic [1:0] op_be;
		logic req_ready;
		logic resp_valid;
		logic [15:0] resp_rdata;
	} lghp_host_reg_t;

	lghp_host_reg_t r;
	lghp_host_reg_t next_r;

	// next state
	always_comb begin
		next_r = r;
		next_r.resp_valid = 1'b0;
		next_r.wait_s1 = bus.wait_n;
		next_r.wait_s2 = r.wait_s1;
		next_r.data_s1 = bus.host_data_io;
		next_r.data_s2 = r.data_s1;
		next_r.bs = mode_shared_sel;
		next_r.endian = big_endian_sel;
		// bus clock divider
		if (r.div_cnt == lghp_pkg::BUS_CLOCK_HALF - 3'h1) begin
			next_r.div_cnt = 3'h0;
			next_r.bclk = ~r.bclk;
		end else begin
			next_r.div_cnt = r.div_cnt + 3'h1;
		end
		unique case (r.state)
			lghp_pkg::H_IDLE: begin
				if (req_valid) begin
					next_r.req_ready = 1'b0;
					next_r.op_write = req_write;
					next_r.op_be = req_byte_en;
					next_r.cs_n = 1'b0;
					next_r.addr = r.bs ? {req_addr[16:1], ~req_byte_en[0]}
						: {req_addr[16:1], 1'b0};
					next_r.dout = req_wdata;
					next_r.state = lghp_pkg::H_SETUP;
				end
			end
			lghp_pkg::H_SETUP: begin
				// drive data only now: the device may still hold the lines after a read
				next_r.doe = r.op_write;
				if (r.bs) begin
					next_r.we0_n = ~r.op_write;
					next_r.rd0_n = r.op_write;
					next_r.we1_n = ~r.op_be[1];
					next_r.rd1_n = 1'b1;
				end else begin
					next_r.we0_n = ~(r.op_write & r.op_be[0]);
					next_r.we1_n = ~(r.op_write & r.op_be[1]);
					next_r.rd0_n = ~(~r.op_write & r.op_be[0]);
					next_r.rd1_n = ~(~r.op_write & r.op_be[1]);
				end
				next_r.state = lghp_pkg::H_STROBE;
			end
			lghp_pkg::H_STROBE: begin
				if (!r.wait_s2) begin
					next_r.state = lghp_pkg::H_WAIT_HI;
				end
			end
			lghp_pkg::H_WAIT_HI: begin
				// cycle is stretched until wait releases
				if (r.wait_s2) begin
					next_r.resp_rdata = r.op_write ? 16'h0000 : r.data_s2;
					next_r.resp_valid = 1'b1;
					next_r.we0_n = 1'b1;
					next_r.we1_n = 1'b1;
					next_r.rd0_n = 1'b1;
					next_r.rd1_n = 1'b1;
					next_r.state = lghp_pkg::H_HOLD;
				end
			end
			lghp_pkg::H_HOLD: begin
				next_r.cs_n = 1'b1;
				next_r.doe = 1'b0;
				next_r.req_ready = 1'b1;
				next_r.state = lghp_pkg::H_IDLE;
			end
			default: begin
				next_r.state = lghp_pkg::H_IDLE;
			end
		endcase
	end

	// state register, all strobes inactive in reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
			r.wait_s1 <= 1'b1;
			r.wait_s2 <= 1'b1;
			r.cs_n <= 1'b1;
			r.we0_n <= 1'b1;
			r.we1_n <= 1'b1;
			r.rd0_n <= 1'b1;
			r.rd1_n <= 1'b1;
			r.req_ready <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// pins and user outputs straight from flops
	assign bus.chip_select_n = r.cs_n;
	assign bus.low_byte_write_strobe_n = r.we0_n;
	assign bus.high_byte_write_strobe_n = r.we1_n;
	assign bus.read_strobe_n = r.rd0_n;
	assign bus.high_byte_read_strobe_n = r.rd1_n;
	assign bus.host_addr_in = r.addr;
	assign bus.host_data_out = r.dout;
	assign bus.host_data_oe = r.doe;
	assign bus.host_port_clock_in = r.bclk;
	assign bus.bus_status_strap = r.bs;
	assign bus.endian_strap = r.endian;
	assign req_ready = r.req_ready;
	assign resp_valid = r.resp_valid;
	assign resp_rdata = r.resp_rdata;
endmodule
`default_nettype wire

// ===== verif/lghp_asserts.sv
/*
 checker of the pins between the host end and the device end of the port.
 assumes one clk domain for both ends and reset_n asynchronous, active low.
*/
`timescale 1ns/100ps
`default_nettype none
module lghp_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// strobes and select
	input wire logic chip_select_n,
	input wire logic low_byte_write_strobe_n,
	input wire logic high_byte_write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic high_byte_read_strobe_n,
	// data drivers, wait and bus clock
	input wire logic dev_data_oe,
	input wire logic host_data_oe,
	input wire logic wait_n,
	input wire logic host_port_clock_in
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// any strobe pin low
	wire logic strobe_on;
	assign strobe_on = !(low_byte_write_strobe_n & high_byte_write_strobe_n & read_strobe_n
		& high_byte_read_strobe_n);
	// bus clock halves of four clk cycles each
	sequence s_bclk_high;
		host_port_clock_in [*4];
	endsequence
	sequence s_bclk_low;
		!host_port_clock_in [*4];
	endsequence
	a_bclk_half_period: assert property (
		$rose(host_port_clock_in) |-> s_bclk_high ##1 s_bclk_low ##1 host_port_clock_in)
		else $error("bus clock half period wrong");
	a_reset_wait_free: assert property (
		$rose(reset_n) |-> wait_n && !dev_data_oe)
		else $error("wait or data driven out of reset");
	a_wait_sync_delay: assert property (
		$fell(chip_select_n) |-> wait_n [*3])
		else $error("wait asserted before strobes synchronised");
	a_wait_needs_access: assert property (
		$fell(wait_n) |-> !chip_select_n && strobe_on)
		else $error("wait asserted without an access");
	a_wait_bounded: assert property (
		$fell(wait_n) |-> ##[1:400] wait_n)
		else $error("wait never released");
	a_host_extends: assert property (
		!wait_n |=> !chip_select_n && strobe_on)
		else $error("host ended cycle during wait");
	a_read_data_release: assert property (
		$rose(dev_data_oe) |-> $rose(wait_n) && !(read_strobe_n & high_byte_read_strobe_n))
		else $error("read data not tied to wait release");
	a_no_write_drive: assert property (
		dev_data_oe |-> low_byte_write_strobe_n)
		else $error("device drives data during a write");
	a_lanes_no_clash: assert property (
		!(dev_data_oe && host_data_oe))
		else $error("both ends drive the data bus");
	a_release_on_bclk: assert property (
		$rose(wait_n) |-> host_port_clock_in)
		else $error("wait released away from bus clock high");
endmodule
`default_nettype wire

// ===== verif/test_lcd_ctrl_generic_host_port.sv
/*
 testbench joining host end and device end through the pin interface.
 assumes the package constants and a 25 MHz clk; straps change only under reset.
*/
`timescale 1ns/100ps
`default_nettype none
module test_lcd_ctrl_generic_host_port;
	typedef struct packed {
		logic w;
		logic [16:0] addr;
		logic [15:0] data;
		logic [1:0] be;
		logic [15:0] exp;
	} lghp_row_t;
	logic clk = 1'h0, reset_n = 1'h0, refresh_busy = 1'h0, mode_sel = 1'h0, endian_sel = 1'h0;
	logic req_valid = 1'h0, req_write = 1'h0;
	logic [16:0] req_addr = 17'h0_0000;
	logic [15:0] req_wdata = 16'h0000;
	logic [1:0] req_byte_en = 2'h3;
	logic req_ready, resp_valid, host_granted, mode_shared, endian_big;
	logic [15:0] resp_rdata;
	logic [3:0] seen = 4'h0;
	logic granted_busy = 1'h0;
	logic seen_clr = 1'h0;
	int n_fail = 0, n_tests = 0, cycles = 0;
	lghp_row_t rows [12];
	lghp_if bus ();
	lghp_dev u_lghp_dev (.clk(clk), .reset_n(reset_n), .bus(bus.dev), .refresh_busy(refresh_busy),
		.host_granted(host_granted), .mode_shared(mode_shared), .endian_big(endian_big));
	lghp_host u_lghp_host (.clk(clk), .reset_n(reset_n), .bus(bus.host),
		.mode_shared_sel(mode_sel), .big_endian_sel(endian_sel), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_byte_en(req_byte_en), .req_ready(req_ready), .resp_valid(resp_valid),
		.resp_rdata(resp_rdata));
	lghp_asserts u_lghp_asserts (.clk(clk), .reset_n(reset_n), .chip_select_n(bus.chip_select_n),
		.low_byte_write_strobe_n(bus.low_byte_write_strobe_n),
		.high_byte_write_strobe_n(bus.high_byte_write_strobe_n),
		.read_strobe_n(bus.read_strobe_n), .high_byte_read_strobe_n(bus.high_byte_read_strobe_n),
		.dev_data_oe(bus.dev_data_oe), .host_data_oe(bus.host_data_oe), .wait_n(bus.wait_n),
		.host_port_clock_in(bus.host_port_clock_in));
	// clock
	always #20 clk = ~clk;
	// record strobes seen low and grants given while refresh owns memory, off the launch edge
	always @(negedge clk) begin
		if (seen_clr) begin
			seen <= 4'h0;
		end else begin
			seen <= seen | ~{bus.high_byte_read_strobe_n, bus.read_strobe_n,
				bus.high_byte_write_strobe_n, bus.low_byte_write_strobe_n};
		end
		if (host_granted && refresh_busy) begin
			granted_busy <= 1'h1;
		end
	end
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			final_report();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic access(input lghp_row_t r, input logic m);
		int k;
		k = 0;
		while (req_ready !== 1'h1 && k < 300) begin
			@(posedge clk);
			#2;
			k++;
		end
		chk(req_ready, 1'h1);
		req_valid = 1'h1;
		req_write = r.w;
		req_addr = r.addr;
		req_wdata = r.data;
		req_byte_en = r.be;
		seen_clr = 1'h1;
		@(posedge clk);
		#2;
		req_valid = 1'h0;
		seen_clr = 1'h0;
		k = 0;
		while (resp_valid !== 1'h1 && k < 300) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk(resp_valid, 1'h1);
		if (!r.w) begin
			chk(resp_rdata, r.exp);
		end
		chk(seen, m ? {1'h0, !r.w, r.be[1], r.w} : (r.w ? {2'h0, r.be} : {r.be, 2'h0}));
		#1;
	endtask
	task automatic do_reset(input logic m, input logic e);
		reset_n = 1'h0;
		mode_sel = m;
		endian_sel = e;
		repeat (5) @(posedge clk);
		#1;
		chk(bus.wait_n, 1'h1);
		chk(bus.dev_data_oe, 1'h0);
		#1;
		reset_n = 1'h1;
		repeat (8) @(posedge clk);
		#2;
		chk(bus.bus_status_strap, m);
		chk(mode_shared, m);
		chk(endian_big, e);
	endtask
	task automatic final_report();
		$display("tests=%0d fails=%0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// main sequence: every mode and byte order over the table, then refresh contention
	initial begin
		rows = '{'{1'h1, 17'h0_0000, 16'h1234, 2'h3, 16'h0000},
			'{1'h0, 17'h0_0000, 16'h0000, 2'h3, 16'h1234},
			'{1'h0, 17'h0_0000, 16'h0000, 2'h2, 16'h1200},
			'{1'h1, 17'h1_3FFE, 16'hFFFF, 2'h3, 16'h0000},
			'{1'h1, 17'h1_3FFE, 16'hA5C3, 2'h1, 16'h0000},
			'{1'h0, 17'h1_3FFE, 16'h0000, 2'h3, 16'hFFC3},
			'{1'h1, 17'h1_FFE0, 16'hBEEF, 2'h3, 16'h0000},
			'{1'h1, 17'h1_FFFE, 16'h0F0F, 2'h3, 16'h0000},
			'{1'h0, 17'h1_FFE0, 16'h0000, 2'h3, 16'hBEEF},
			'{1'h0, 17'h1_FFFE, 16'h0000, 2'h3, 16'h0F0F},
			'{1'h1, 17'h1_4000, 16'h7777, 2'h3, 16'h0000},
			'{1'h0, 17'h1_4000, 16'h0000, 2'h3, 16'h0000}};
		for (int c = 0; c < 4; c++) begin
			do_reset(c[0], c[1]);
			for (int i = 0; i < 12; i++) begin
				access(rows[i], c[0]);
			end
		end
		refresh_busy = 1'h1;
		fork
			access(rows[0], 1'h1);
			begin
				repeat (60) @(posedge clk);
				#1;
				chk(bus.wait_n, 1'h0);
				chk(resp_valid, 1'h0);
				#1;
				refresh_busy = 1'h0;
			end
		join
		chk(granted_busy, 1'h0);
		access(rows[1], 1'h1);
		final_report();
	end
endmodule
`default_nettype wire
